// [hw/sr4_params.svh]
`ifndef SR4_PARAMS_SVH
`define SR4_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define SR4_WIDTH        4
`define SR4_BUF_DEPTH    2
`define SR4_PIN_COUNT    8

// ----------------------------------------------------------------
// Reset values and constant levels
// ----------------------------------------------------------------
`define SR4_STAGE_RST    4'h0
`define SR4_OE_RST       4'h0
`define SR4_OE_ON        4'hF
`define SR4_PIN_RST      8'h00
`define SR4_BIT_RST      1'h0
`define SR4_BIT_ONE      1'h1

// ----------------------------------------------------------------
// Positions inside the synchronised pin vector
// ----------------------------------------------------------------
`define SR4_PIN_CLK      0
`define SR4_PIN_MODE     1
`define SR4_PIN_SERIAL   2
`define SR4_PIN_CLEAR_N  3
`define SR4_PIN_DRIVE_N  4
`define SR4_PIN_PAR_LO   5

`endif

// [hw/sr4_pkg.sv]
package sr4_pkg;

	// ----------------------------------------------------------------
	// Mode select levels
	// ----------------------------------------------------------------
	typedef enum logic {
		SR4_MODE_SHIFT,
		SR4_MODE_LOAD
	} sr4_mode_t;

endpackage

// [hw/sr4_sync.sv]
`timescale 1ns/10ps
`include "sr4_params.svh"

module sr4_sync
	import sr4_pkg::*;
#(
	parameter int          WIDTH = `SR4_PIN_COUNT,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Pins
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ----------------------------------------------------------------
	// Two flip-flop synchroniser
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;

endmodule

// [hw/sr4_buf.sv]
`timescale 1ns/10ps
`include "sr4_params.svh"

module sr4_buf
	import sr4_pkg::*;
#(
	parameter int WIDTH = `SR4_WIDTH,
	parameter int DEPTH = `SR4_BUF_DEPTH
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	// ----------------------------------------------------------------
	// Shifting store
	// ----------------------------------------------------------------
	// Entries move toward slot zero so the head is always a flop.
	logic [WIDTH-1:0] mem_reg   [DEPTH];
	logic [WIDTH-1:0] mem_next  [DEPTH];
	logic [DEPTH-1:0] full_reg;
	logic [DEPTH-1:0] full_next;

	always_comb begin
		logic             pop;
		logic             push;
		logic [DEPTH-1:0] keep;
		pop  = full_reg[0] & out_ready;
		push = in_valid & ~full_reg[DEPTH-1];
		keep = pop ? (full_reg >> 1) : full_reg;
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
			if (pop) begin
				mem_next[i] = (i < DEPTH - 1) ? mem_reg[(i + 1) % DEPTH] : mem_reg[i];
			end
		end
		full_next = keep;
		for (int i = 0; i < DEPTH; i++) begin
			if (push && !keep[i] && (i == 0 || keep[(i + DEPTH - 1) % DEPTH])) begin
				mem_next[i]  = in_data;
				full_next[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			full_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else begin
			full_reg <= full_next;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= mem_next[i];
			end
		end
	end

	assign in_ready  = ~full_reg[DEPTH-1];
	assign out_valid = full_reg[0];
	assign out_data  = mem_reg[0];

endmodule

// [hw/sr4_shift_reg.sv]
`timescale 1ns/10ps
`include "sr4_params.svh"

// Contract
// - Four storage stages; each takes its parallel input or the stage before it, stage zero the serial input.
// - Apart from clear, stages change only on a falling edge of the clock pin.
// - Mode HIGH: falling edge loads every stage from its parallel input bit.
// - Mode LOW: falling edge copies the serial input into stage zero.
// - Shift mode moves stage zero to one, one to two, two to three.
// - Drive enable HIGH floats all four outputs; LOW drives the stored stages.
// - Shift, load and clear work inside while the outputs float.
// - Clear LOW forces all stages LOW at once, over every other input.
module sr4_shift_reg
	import sr4_pkg::*;
#(
	parameter int WIDTH = `SR4_WIDTH,
	parameter int DEPTH = `SR4_BUF_DEPTH
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Control pins
	input  wire logic             shift_clk_pin,
	input  wire logic             mode_pick,
	input  wire logic             async_clear_n,
	input  wire logic             drive_enable_n,
	// Data pins
	input  wire logic             serial_in,
	input  wire logic [WIDTH-1:0] par_in,
	// Three-state outputs
	output logic      [WIDTH-1:0] stage_out,
	output logic      [WIDTH-1:0] stage_oe,
	// Stage word stream
	output logic                  word_valid,
	input  wire logic             word_ready,
	output logic      [WIDTH-1:0] word_data
);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	localparam int PINS = `SR4_PIN_PAR_LO + WIDTH;
	// The drive enable leaves reset inactive, so the outputs stay
	// released until the pin itself has been seen.
	localparam logic [PINS-1:0] PINS_RST = PINS'(`SR4_BIT_ONE) << `SR4_PIN_DRIVE_N;

	logic [PINS-1:0] pins_raw;
	logic [PINS-1:0] pins_sync;

	assign pins_raw = {par_in, drive_enable_n, async_clear_n, serial_in,
		mode_pick, shift_clk_pin};

	sr4_sync #(
		.WIDTH   (PINS),
		.RST_VAL (PINS_RST)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);

	logic             clk_s;
	logic             serial_s;
	logic             clear_n_s;
	logic             drive_n_s;
	logic [WIDTH-1:0] par_s;
	sr4_mode_t        mode_s;

	assign clk_s     = pins_sync[`SR4_PIN_CLK];
	assign serial_s  = pins_sync[`SR4_PIN_SERIAL];
	assign clear_n_s = pins_sync[`SR4_PIN_CLEAR_N];
	assign drive_n_s = pins_sync[`SR4_PIN_DRIVE_N];
	assign par_s     = pins_sync[`SR4_PIN_PAR_LO +: WIDTH];
	assign mode_s    = pins_sync[`SR4_PIN_MODE] ? SR4_MODE_LOAD : SR4_MODE_SHIFT;

	// ----------------------------------------------------------------
	// Clock pin edge detection
	// ----------------------------------------------------------------
	// Only a HIGH-to-LOW step of the clock pin counts; the rising
	// step is seen but ignored.
	logic clk_prev_reg;
	logic clk_prev_next;
	logic fall;

	always_comb begin
		clk_prev_next = clk_s;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			clk_prev_reg <= `SR4_BIT_RST;
		end else begin
			clk_prev_reg <= clk_prev_next;
		end
	end

	assign fall = clk_prev_reg & ~clk_s;

	// ----------------------------------------------------------------
	// Stage update
	// ----------------------------------------------------------------
	// An edge that meets a full buffer waits as pending and the
	// pin data of its own cycle is held with it. Two edges during one
	// stall merge into one: the reader must not stall for long.
	logic             buf_in_ready;
	logic             go;
	logic             pend_reg;
	logic             pend_next;
	logic             pmode_reg;
	logic             pmode_next;
	logic             pser_reg;
	logic             pser_next;
	logic [WIDTH-1:0] ppar_reg;
	logic [WIDTH-1:0] ppar_next;
	logic [WIDTH-1:0] stage_reg;
	logic [WIDTH-1:0] stage_next;

	always_comb begin
		logic             use_mode;
		logic             use_ser;
		logic [WIDTH-1:0] use_par;
		pmode_next = pmode_reg;
		pser_next  = pser_reg;
		ppar_next  = ppar_reg;
		if (fall) begin
			pmode_next = (mode_s == SR4_MODE_LOAD);
			pser_next  = serial_s;
			ppar_next  = par_s;
		end
		use_mode   = fall ? (mode_s == SR4_MODE_LOAD) : pmode_reg;
		use_ser    = fall ? serial_s : pser_reg;
		use_par    = fall ? par_s : ppar_reg;
		go         = (fall | pend_reg) & buf_in_ready & clear_n_s;
		pend_next  = (fall | pend_reg) & ~go & clear_n_s;
		stage_next = stage_reg;
		if (!clear_n_s) begin
			stage_next = `SR4_STAGE_RST;
		end else if (go) begin
			if (use_mode) begin
				stage_next = use_par;
			end else begin
				stage_next = {stage_reg[WIDTH-2:0], use_ser};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pend_reg  <= `SR4_BIT_RST;
			pmode_reg <= `SR4_BIT_RST;
			pser_reg  <= `SR4_BIT_RST;
			ppar_reg  <= `SR4_STAGE_RST;
			stage_reg <= `SR4_STAGE_RST;
		end else begin
			pend_reg  <= pend_next;
			pmode_reg <= pmode_next;
			pser_reg  <= pser_next;
			ppar_reg  <= ppar_next;
			stage_reg <= stage_next;
		end
	end

	// ----------------------------------------------------------------
	// Output drivers
	// ----------------------------------------------------------------
	// The enable touches only the drivers, never the stages.
	logic [WIDTH-1:0] oe_reg;
	logic [WIDTH-1:0] oe_next;

	always_comb begin
		oe_next = drive_n_s ? `SR4_OE_RST : `SR4_OE_ON;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			oe_reg <= `SR4_OE_RST;
		end else begin
			oe_reg <= oe_next;
		end
	end

	assign stage_out = stage_reg;
	assign stage_oe  = oe_reg;

	// ----------------------------------------------------------------
	// Stage word stream
	// ----------------------------------------------------------------
	// Every clocked update pushes the new stage word. A stalled
	// reader holds one edge back; further edges in the same stall merge with it, and one word, built from the last edge's pin data, is pushed.
	sr4_buf #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_buf (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (go),
		.in_ready  (buf_in_ready),
		.in_data   (stage_next),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (word_data)
	);

endmodule

// [testbench/sr4_shift_reg_asserts.sv]
`timescale 1ns/10ps
module sr4_shift_reg_asserts
	import sr4_pkg::*;
#(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic             core_clk,
	input wire logic             rst,
	// Pins
	input wire logic             shift_clk_pin,
	input wire logic             mode_pick,
	input wire logic             async_clear_n,
	input wire logic             drive_enable_n,
	input wire logic             serial_in,
	input wire logic [WIDTH-1:0] par_in,
	// Outputs and stream
	input wire logic [WIDTH-1:0] stage_out,
	input wire logic [WIDTH-1:0] stage_oe,
	input wire logic             word_valid,
	input wire logic             word_ready,
	input wire logic [WIDTH-1:0] word_data
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// A falling clock pin with an empty stream, so the update is not held back.
	sequence fall_in(logic m);
		$fell(shift_clk_pin) && mode_pick == m && async_clear_n && word_ready && !word_valid;
	endsequence

	a_oe_uniform: assert property (stage_oe == '0 || stage_oe == '1)
		else $error("enables differ");
	a_oe_on: assert property (!drive_enable_n [*6] |-> stage_oe == '1)
		else $error("outputs not driven");
	a_oe_off: assert property (drive_enable_n [*6] |-> stage_oe == '0)
		else $error("outputs not released");
	a_clear_zero: assert property (!async_clear_n [*5] |-> stage_out == '0)
		else $error("clear ignored");
	a_hold_idle: assert property
		(($stable(shift_clk_pin) && async_clear_n && !word_ready) [*6] |=> $stable(stage_out))
		else $error("stages moved");
	a_rise_ignored: assert property ($rose(shift_clk_pin) && async_clear_n |=>
		$stable(stage_out) [*5])
		else $error("rising edge acted");
	a_shift_step: assert property (fall_in(1'b0) |-> ##5
		stage_out[WIDTH-1:1] == $past(stage_out[WIDTH-2:0], 5) && stage_out[0] == $past(serial_in, 5))
		else $error("bad shift");
	a_load_step: assert property (fall_in(1'b1) |-> ##5 stage_out == $past(par_in, 5))
		else $error("bad load");
	a_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
		else $error("word dropped");
endmodule

bind sr4_shift_reg sr4_shift_reg_asserts #(.WIDTH(WIDTH)) u_chk (.core_clk, .rst, .shift_clk_pin,
	.mode_pick, .async_clear_n, .drive_enable_n, .serial_in, .par_in, .stage_out, .stage_oe,
	.word_valid, .word_ready, .word_data);

// [testbench/sr4_pin_drv.sv]
`timescale 1ns/10ps
module sr4_pin_drv (
	// Clock
	input wire logic       core_clk,
	// Stage feedback
	input wire logic [3:0] stage_out,
	// Pins
	output logic           shift_clk_pin,
	output logic           mode_pick,
	output logic           serial_in,
	output logic [3:0]     par_in
);
	initial begin
		shift_clk_pin = 1'h1;
		mode_pick = 1'h0;
		serial_in = 1'h0;
		par_in = 4'h0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Data is inverted once its hold has run out, so stale values cannot pass.
	task automatic pulse(input logic m, input logic s, input logic [3:0] p);
		mode_pick = m;
		serial_in = s;
		par_in = p;
		step(4);
		shift_clk_pin = ~shift_clk_pin;
		step(4);
		shift_clk_pin = ~shift_clk_pin;
		step(4);
		serial_in = ~s;
		par_in = ~p;
		step(1);
	endtask

	task automatic lshift(input logic link);
		pulse(1'h1, 1'h0, {link, stage_out[3:1]});
	endtask
endmodule

// [testbench/sr4_shift_reg_tb.sv]
`timescale 1ns/10ps
module sr4_shift_reg_tb
	import sr4_pkg::*;
;
	logic       core_clk, rst, async_clear_n, drive_enable_n, word_ready;
	logic       shift_clk_pin, mode_pick, serial_in, word_valid;
	logic [3:0] par_in, stage_out, stage_oe, word_data;
	wire  [3:0] pins;
	logic [3:0] got[$];
	int         err_count, checked;

	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end

	sr4_shift_reg dut (.core_clk, .rst, .shift_clk_pin, .mode_pick, .async_clear_n,
		.drive_enable_n, .serial_in, .par_in, .stage_out, .stage_oe, .word_valid,
		.word_ready, .word_data);
	sr4_pin_drv drv (.core_clk, .stage_out, .shift_clk_pin, .mode_pick, .serial_in, .par_in);

	for (genvar i = 0; i < 4; i++) begin : g_pad
		assign pins[i] = stage_oe[i] ? stage_out[i] : 1'bz;
	end

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic set_ctl(input logic r, input logic c, input logic e, input logic w);
		rst = r;
		async_clear_n = c;
		drive_enable_n = e;
		word_ready = w;
	endtask

	task automatic end_of_test;
		$display("mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic t_modes;
		drv.pulse(1'h1, 1'h0, 4'hA);
		check(stage_out, 4'hA);
		check(pins, 4'hA);
		drv.pulse(1'h0, 1'h1, 4'h0);
		check(stage_out, 4'h5);
		drv.pulse(1'h0, 1'h0, 4'hF);
		check(stage_out, 4'hA);
		drv.lshift(1'h1);
		check(stage_out, 4'hD);
	endtask

	task automatic t_float;
		set_ctl(1'h0, 1'h1, 1'h1, 1'h1);
		drv.step(6);
		check(pins, 4'hZ);
		drv.pulse(1'h1, 1'h0, 4'h3);
		check(stage_out, 4'h3);
		set_ctl(1'h0, 1'h1, 1'h0, 1'h1);
		drv.step(6);
		check(pins, 4'h3);
	endtask

	task automatic t_clear;
		set_ctl(1'h0, 1'h0, 1'h0, 1'h1);
		drv.step(6);
		check(stage_out, 4'h0);
		drv.pulse(1'h1, 1'h0, 4'hF);
		check(stage_out, 4'h0);
		set_ctl(1'h0, 1'h1, 1'h0, 1'h1);
		drv.step(6);
		check(stage_out, 4'h0);
	endtask

	// The third edge waits while both buffer entries are full.
	task automatic t_stall;
		set_ctl(1'h0, 1'h1, 1'h0, 1'h0);
		drv.pulse(1'h1, 1'h0, 4'h1);
		drv.pulse(1'h1, 1'h0, 4'h2);
		drv.pulse(1'h1, 1'h0, 4'h4);
		check(stage_out, 4'h2);
		set_ctl(1'h0, 1'h1, 1'h0, 1'h1);
		repeat (20) begin
			if (word_valid === 1'h1) got.push_back(word_data);
			drv.step(1);
		end
		check(4'(got.size()), 4'h3);
		foreach (got[i]) check(got[i], 4'(1 << i));
		check(stage_out, 4'h4);
	endtask

	initial begin
		set_ctl(1'h1, 1'h1, 1'h0, 1'h1);
		err_count = 0;
		checked = 0;
		repeat (6) @(posedge core_clk);
		#1 set_ctl(1'h0, 1'h1, 1'h0, 1'h1);
		drv.step(3);
		t_modes;
		t_float;
		t_clear;
		t_stall;
		end_of_test;
	end

	initial begin
		#100000;
		err_count++;
		end_of_test;
	end
endmodule
